// file: logic/jct_tap.v
// test access port of a programmable clock generator: controller, instructions, data path
// assumes link pins arrive asynchronously; tck edges are found by sampling with clk_i
`timescale 1ns/1ps
`include "jct_consts.vh"
module jct_tap #(
   parameter COL_W = `JCT_COL_W,
   parameter BSR_W = `JCT_BSR_W,
   parameter ID    = `JCT_ID_VALUE
) (
   input  wire                   clk_i,
   input  wire                   rstn_i,
   input  wire                   tck_i,
   input  wire                   tms_i,
   input  wire                   tdi_i,
   output reg                    tdo_o,
   output reg                    tdo_oe_o,
   input  wire [BSR_W-1:0]       pins_i,
   output wire [BSR_W-1:0]       bsr_drive_o,
   output wire                   pins_from_bsr_o,
   output wire                   outputs_highz_o,
   output wire                   intest_o,
   output wire                   prog_mode_o,
   output wire                   config_done_o,
   output wire                   lock_fuse_o,
   output wire [`JCT_ADDR_W-1:0] mem_addr_o,
   output reg                    mem_col_wr_o,
   output wire [COL_W-1:0]       mem_col_wdata_o,
   input  wire [COL_W-1:0]       mem_col_rdata_i,
   output reg                    mem_erase_o,
   output reg                    mem_sig_wr_o,
   output wire [`JCT_SIG_W-1:0]  mem_sig_wdata_o,
   input  wire [`JCT_SIG_W-1:0]  mem_sig_rdata_i
);
   wire tck_rise;
   wire tck_fall;
   wire tms_s;
   wire tdi_s;

   jct_sync u_tck (.clk_i(clk_i), .rstn_i(rstn_i), .async_i(tck_i),
      .level_o(), .rise_o(tck_rise), .fall_o(tck_fall));
   jct_sync u_tms (.clk_i(clk_i), .rstn_i(rstn_i), .async_i(tms_i),
      .level_o(tms_s), .rise_o(), .fall_o());
   jct_sync u_tdi (.clk_i(clk_i), .rstn_i(rstn_i), .async_i(tdi_i),
      .level_o(tdi_s), .rise_o(), .fall_o());

   reg [15:0] state_reg;
   reg [15:0] state_next;

   always @* begin
      case (state_reg)
         `JCT_ST_RESET: state_next = tms_s ? `JCT_ST_RESET : `JCT_ST_IDLE;
         `JCT_ST_IDLE:  state_next = tms_s ? `JCT_ST_SELDR : `JCT_ST_IDLE;
         `JCT_ST_SELDR: state_next = tms_s ? `JCT_ST_SELIR : `JCT_ST_CAPDR;
         `JCT_ST_CAPDR: state_next = tms_s ? `JCT_ST_EX1DR : `JCT_ST_SHDR;
         `JCT_ST_SHDR:  state_next = tms_s ? `JCT_ST_EX1DR : `JCT_ST_SHDR;
         `JCT_ST_EX1DR: state_next = tms_s ? `JCT_ST_UPDR  : `JCT_ST_PAUDR;
         `JCT_ST_PAUDR: state_next = tms_s ? `JCT_ST_EX2DR : `JCT_ST_PAUDR;
         `JCT_ST_EX2DR: state_next = tms_s ? `JCT_ST_UPDR  : `JCT_ST_SHDR;
         `JCT_ST_UPDR:  state_next = tms_s ? `JCT_ST_SELDR : `JCT_ST_IDLE;
         `JCT_ST_SELIR: state_next = tms_s ? `JCT_ST_RESET : `JCT_ST_CAPIR;
         `JCT_ST_CAPIR: state_next = tms_s ? `JCT_ST_EX1IR : `JCT_ST_SHIR;
         `JCT_ST_SHIR:  state_next = tms_s ? `JCT_ST_EX1IR : `JCT_ST_SHIR;
         `JCT_ST_EX1IR: state_next = tms_s ? `JCT_ST_UPIR  : `JCT_ST_PAUIR;
         `JCT_ST_PAUIR: state_next = tms_s ? `JCT_ST_EX2IR : `JCT_ST_PAUIR;
         `JCT_ST_EX2IR: state_next = tms_s ? `JCT_ST_UPIR  : `JCT_ST_SHIR;
         `JCT_ST_UPIR:  state_next = tms_s ? `JCT_ST_SELDR : `JCT_ST_IDLE;
         default:       state_next = `JCT_ST_RESET;
      endcase
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= `JCT_ST_RESET;
      end else if (tck_rise) begin
         state_reg <= state_next;
      end
   end

   wire in_reset = (state_reg == `JCT_ST_RESET);
   wire in_capdr = (state_reg == `JCT_ST_CAPDR);
   wire in_shdr  = (state_reg == `JCT_ST_SHDR);
   wire in_updr  = (state_reg == `JCT_ST_UPDR);
   wire in_capir = (state_reg == `JCT_ST_CAPIR);
   wire in_shir  = (state_reg == `JCT_ST_SHIR);
   wire in_upir  = (state_reg == `JCT_ST_UPIR);
   wire enter_idle = tck_rise & (state_next == `JCT_ST_IDLE) & (state_reg != `JCT_ST_IDLE);

   reg idle_entry_reg;

   // idle entry one clock late, so an instruction adopted on that same edge still counts
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle_entry_reg <= 1'b0;
      end else begin
         idle_entry_reg <= enter_idle;
      end
   end

   // one step per tck rise while in the named state
   wire capdr = tck_rise & in_capdr;
   wire shdr  = tck_rise & in_shdr;
   wire updr  = tck_rise & in_updr;
   wire capir = tck_rise & in_capir;
   wire shir  = tck_rise & in_shir;
   wire upir  = tck_rise & in_upir;

   // instruction path
   wire [`JCT_IR_W-1:0] ir_shift;
   wire                 ir_out;
   reg  [`JCT_IR_W-1:0] instr_reg;
   reg                  pend_reg;

   jct_shreg #(.W(`JCT_IR_W)) u_ir (.clk_i(clk_i), .rstn_i(rstn_i), .load_i(capir),
      .load_data_i(`JCT_IR_CAPTURE), .shift_i(shir), .serial_i(tdi_s),
      .serial_o(ir_out), .data_o(ir_shift));

   // reset selects identification; update adopts new code
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         instr_reg <= `JCT_OP_IDCODE;
         pend_reg  <= 1'b0;
      end else if (tck_rise & in_reset) begin
         instr_reg <= `JCT_OP_IDCODE;
         pend_reg  <= 1'b0;
      end else if (upir) begin
         instr_reg <= ir_shift;
         pend_reg  <= 1'b1;
      end else if (idle_entry_reg) begin
         pend_reg  <= 1'b0;
      end
   end

   // full eight-bit decode, used for select and actions
   function is_op;
      input [`JCT_IR_W-1:0] code;
      input [`JCT_IR_W-1:0] op;
      begin
         is_op = ~code[`JCT_IR_MSB] & (code == op);
      end
   endfunction

   wire op_bypass = instr_reg[`JCT_IR_MSB];
   wire op_extest = is_op(instr_reg, `JCT_OP_EXTEST);
   wire op_sample = is_op(instr_reg, `JCT_OP_SAMPLE);
   wire op_clamp  = is_op(instr_reg, `JCT_OP_CLAMP) | is_op(instr_reg, `JCT_OP_NOOP);
   wire op_highz  = is_op(instr_reg, `JCT_OP_HIGHZ);
   wire op_intest = is_op(instr_reg, `JCT_OP_INTEST);
   wire op_addr   = is_op(instr_reg, `JCT_OP_ADDR_SHIFT);
   wire op_rdcol  = is_op(instr_reg, `JCT_OP_RD_COL) | is_op(instr_reg, `JCT_OP_RD_COL_STEP);
   wire op_wrcol  = is_op(instr_reg, `JCT_OP_WR_COL) | is_op(instr_reg, `JCT_OP_WR_COL_STEP);
   wire op_col    = is_op(instr_reg, `JCT_OP_DATA_SHIFT) | op_rdcol | op_wrcol;
   wire op_sig    = is_op(instr_reg, `JCT_OP_RD_SIG) | is_op(instr_reg, `JCT_OP_WR_SIG);
   wire op_bsr    = op_extest | op_sample | op_clamp | op_intest;

   reg [2:0] sel;

   always @* begin
      if (op_bypass) begin
         sel = `JCT_SEL_BYPASS;
      end else if (op_bsr) begin
         sel = `JCT_SEL_BSR;
      end else if (is_op(instr_reg, `JCT_OP_IDCODE)) begin
         sel = `JCT_SEL_ID;
      end else if (op_addr) begin
         sel = `JCT_SEL_ADDR;
      end else if (op_col) begin
         sel = `JCT_SEL_COL;
      end else if (op_sig) begin
         sel = `JCT_SEL_SIG;
      end else begin
         sel = `JCT_SEL_BYPASS;
      end
   end

   // data registers
   reg  [`JCT_ADDR_W-1:0] addr_reg;
   reg  [COL_W-1:0]       col_reg;
   reg  [`JCT_SIG_W-1:0]  sig_reg;
   reg  [BSR_W-1:0]       bsr_reg;
   reg  [BSR_W-1:0]       bsr_hold_reg;
   reg                    byp_reg;
   reg                    prog_reg;
   reg                    done_reg;
   reg                    fuse_reg;
   wire [`JCT_ID_W-1:0]   id_shift;
   wire                   id_out;

   jct_shreg #(.W(`JCT_ID_W)) u_id (.clk_i(clk_i), .rstn_i(rstn_i),
      .load_i(capdr & (sel == `JCT_SEL_ID)), .load_data_i(ID),
      .shift_i(shdr & (sel == `JCT_SEL_ID)), .serial_i(tdi_s),
      .serial_o(id_out), .data_o(id_shift));

   // operation strobes
   wire run_op  = idle_entry_reg & pend_reg & prog_reg;
   wire do_wcol = run_op & op_wrcol;
   wire do_rcol = run_op & op_rdcol;
   wire do_step = run_op & (is_op(instr_reg, `JCT_OP_WR_COL_STEP) |
                            is_op(instr_reg, `JCT_OP_RD_COL_STEP));

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         addr_reg     <= {`JCT_ADDR_W{1'b0}};
         col_reg      <= {COL_W{1'b0}};
         sig_reg      <= {`JCT_SIG_W{1'b0}};
         bsr_reg      <= {BSR_W{1'b0}};
         bsr_hold_reg <= {BSR_W{1'b0}};
         byp_reg      <= 1'b0;
      end else begin
         if (capdr) begin
            byp_reg <= 1'b0;
         end else if (shdr) begin
            byp_reg <= tdi_s;
         end
         if (capdr & (sel == `JCT_SEL_BSR)) begin
            bsr_reg <= pins_i;
         end else if (shdr & (sel == `JCT_SEL_BSR)) begin
            bsr_reg <= {tdi_s, bsr_reg[BSR_W-1:1]};
         end
         // update latches shifted boundary pattern for driving pins
         if (updr & (sel == `JCT_SEL_BSR)) begin
            bsr_hold_reg <= bsr_reg;
         end
         if (shdr & (sel == `JCT_SEL_ADDR)) begin
            addr_reg <= {tdi_s, addr_reg[`JCT_ADDR_W-1:1]};
         end else if (do_step) begin
            addr_reg <= addr_reg + `JCT_ONE_ADDR;
         end
         // column register, readout blocked by fuse
         if (do_rcol) begin
            col_reg <= fuse_reg ? {COL_W{1'b0}} : mem_col_rdata_i;
         end else if (shdr & (sel == `JCT_SEL_COL)) begin
            col_reg <= {tdi_s, col_reg[COL_W-1:1]};
         end
         // memory copy on capture; shifted value kept for write-back
         if (capdr & (sel == `JCT_SEL_SIG)) begin
            sig_reg <= mem_sig_rdata_i;
         end else if (upir & is_op(ir_shift, `JCT_OP_RD_SIG)) begin
            sig_reg <= mem_sig_rdata_i;
         end else if (shdr & (sel == `JCT_SEL_SIG)) begin
            sig_reg <= {tdi_s, sig_reg[`JCT_SIG_W-1:1]};
         end
      end
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prog_reg     <= 1'b0;
         done_reg     <= 1'b0;
         fuse_reg     <= 1'b0;
         mem_col_wr_o <= 1'b0;
         mem_erase_o  <= 1'b0;
         mem_sig_wr_o <= 1'b0;
      end else begin
         mem_col_wr_o <= do_wcol;
         mem_erase_o  <= run_op & is_op(instr_reg, `JCT_OP_BULK_ERASE);
         mem_sig_wr_o <= run_op & is_op(instr_reg, `JCT_OP_WR_SIG);
         if (upir & is_op(ir_shift, `JCT_OP_PROG_EN)) begin
            prog_reg <= 1'b1;
         end else if (upir & is_op(ir_shift, `JCT_OP_PROG_DIS)) begin
            prog_reg <= 1'b0;
         end
         if (run_op & is_op(instr_reg, `JCT_OP_BULK_ERASE)) begin
            fuse_reg <= 1'b0;
            done_reg <= 1'b0;
         end else if (run_op & is_op(instr_reg, `JCT_OP_WR_FUSE)) begin
            fuse_reg <= 1'b1;
         end else if (run_op & is_op(instr_reg, `JCT_OP_CLR_DONE)) begin
            done_reg <= 1'b0;
         end else if (run_op & is_op(instr_reg, `JCT_OP_SET_DONE)) begin
            done_reg <= 1'b1;
         end
      end
   end

   reg shift_bit;

   always @* begin
      case (sel)
         `JCT_SEL_BSR:  shift_bit = bsr_reg[0];
         `JCT_SEL_ID:   shift_bit = id_out;
         `JCT_SEL_ADDR: shift_bit = addr_reg[0];
         `JCT_SEL_COL:  shift_bit = col_reg[0];
         `JCT_SEL_SIG:  shift_bit = sig_reg[0];
         default:       shift_bit = byp_reg;
      endcase
   end

   // tdo moves on tck fall, driven only when shifting
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (tck_fall) begin
         tdo_o    <= in_shir ? ir_out : shift_bit;
         tdo_oe_o <= in_shir | in_shdr;
      end
   end

   assign pins_from_bsr_o = op_extest | op_clamp;
   assign outputs_highz_o = op_highz;
   assign intest_o        = op_intest;
   assign bsr_drive_o     = bsr_hold_reg;
   assign prog_mode_o     = prog_reg;
   assign config_done_o   = done_reg;
   assign lock_fuse_o     = fuse_reg;
   assign mem_addr_o      = addr_reg;
   assign mem_col_wdata_o = col_reg;
   assign mem_sig_wdata_o = sig_reg;
endmodule

// file: logic/jct_consts.vh
// constants for the configuration test access port
// included by the port controller and its data path modules
`ifndef JCT_CONSTS_VH
`define JCT_CONSTS_VH

// controller states, one-hot, 16 bits
`define JCT_ST_RESET   16'h0001
`define JCT_ST_IDLE    16'h0002
`define JCT_ST_SELDR   16'h0004
`define JCT_ST_CAPDR   16'h0008
`define JCT_ST_SHDR    16'h0010
`define JCT_ST_EX1DR   16'h0020
`define JCT_ST_PAUDR   16'h0040
`define JCT_ST_EX2DR   16'h0080
`define JCT_ST_UPDR    16'h0100
`define JCT_ST_SELIR   16'h0200
`define JCT_ST_CAPIR   16'h0400
`define JCT_ST_SHIR    16'h0800
`define JCT_ST_EX1IR   16'h1000
`define JCT_ST_PAUIR   16'h2000
`define JCT_ST_EX2IR   16'h4000
`define JCT_ST_UPIR    16'h8000

// instruction opcodes, 8 bits
`define JCT_OP_EXTEST      8'h00
`define JCT_OP_ADDR_SHIFT  8'h01
`define JCT_OP_DATA_SHIFT  8'h02
`define JCT_OP_BULK_ERASE  8'h03
`define JCT_OP_WR_COL      8'h07
`define JCT_OP_WR_FUSE     8'h09
`define JCT_OP_RD_COL      8'h0A
`define JCT_OP_DISCHARGE   8'h14
`define JCT_OP_PROG_EN     8'h15
`define JCT_OP_IDCODE      8'h16
`define JCT_OP_RD_SIG      8'h17
`define JCT_OP_WR_SIG      8'h1A
`define JCT_OP_HIGHZ       8'h18
`define JCT_OP_SAMPLE      8'h1C
`define JCT_OP_PROG_DIS    8'h1E
`define JCT_OP_CLAMP       8'h20
`define JCT_OP_CLR_DONE    8'h24
`define JCT_OP_WR_COL_STEP 8'h27
`define JCT_OP_RD_COL_STEP 8'h2A
`define JCT_OP_INTEST      8'h2C
`define JCT_OP_SET_DONE    8'h2F
`define JCT_OP_NOOP        8'h30
`define JCT_IR_MSB         7

// register widths and fixed values
`define JCT_IR_W        8
`define JCT_ADDR_W      10
`define JCT_COL_W       42
`define JCT_SIG_W       32
`define JCT_ID_W        32
`define JCT_BSR_W       8
// arbitrary identification value
`define JCT_ID_VALUE    32'h0ABC_D001
`define JCT_IR_CAPTURE  8'h16
`define JCT_ONE_ADDR    10'h001

// data path selects
`define JCT_SEL_BYPASS  3'h0
`define JCT_SEL_BSR     3'h1
`define JCT_SEL_ID      3'h2
`define JCT_SEL_ADDR    3'h3
`define JCT_SEL_COL     3'h4
`define JCT_SEL_SIG     3'h5

`endif

// file: logic/jct_sync.v
// two-flop synchroniser with edge detection of the synchronised level
// assumes the input is asynchronous to clk_i
`timescale 1ns/1ps
`include "jct_consts.vh"
module jct_sync (
   input  wire clk_i,
   input  wire rstn_i,
   input  wire async_i,
   output wire level_o,
   output wire rise_o,
   output wire fall_o
);
   reg meta_reg;
   reg sync_reg;
   reg last_reg;

   // first flop feeds only the second
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level_o = sync_reg;
   assign rise_o  = sync_reg & ~last_reg;
   assign fall_o  = ~sync_reg & last_reg;
endmodule

// file: logic/jct_shreg.v
// parallel-load shift register, shifting towards bit 0
// assumes load and shift are one-cycle enables, never both at once
`timescale 1ns/1ps
`include "jct_consts.vh"
module jct_shreg #(
   parameter W = 8
) (
   input  wire         clk_i,
   input  wire         rstn_i,
   input  wire         load_i,
   input  wire [W-1:0] load_data_i,
   input  wire         shift_i,
   input  wire         serial_i,
   output wire         serial_o,
   output wire [W-1:0] data_o
);
   reg [W-1:0] data_reg;

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_reg <= {W{1'b0}};
      end else if (load_i) begin
         data_reg <= load_data_i;
      end else if (shift_i) begin
         data_reg <= {serial_i, data_reg[W-1:1]};
      end
   end

   assign serial_o = data_reg[0];
   assign data_o   = data_reg;
endmodule

// file: verification/jct_tap_properties.sv
// checker for the test access port outputs
// bound to jct_tap; sees its ports only
`timescale 1ns/1ps
module jct_tap_properties (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic tck_i,
   input wire logic tdo_o,
   input wire logic tdo_oe_o,
   input wire logic pins_from_bsr_o,
   input wire logic outputs_highz_o,
   input wire logic intest_o,
   input wire logic prog_mode_o,
   input wire logic config_done_o,
   input wire logic lock_fuse_o,
   input wire logic mem_col_wr_o,
   input wire logic mem_erase_o,
   input wire logic mem_sig_wr_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // sync delay puts every tdo change inside the tck low phase
   a_tdo_on_fall: assert property (
      $changed(tdo_o) |-> (!tck_i || !$past(tck_i) || !$past(tck_i, 2)))
      else $error("tdo moved away from a tck fall");
   a_oe_on_fall: assert property (
      $changed(tdo_oe_o) |-> (!tck_i || !$past(tck_i) || !$past(tck_i, 2)))
      else $error("tdo enable moved away from a tck fall");
   a_col_pulse: assert property (
      mem_col_wr_o |=> !mem_col_wr_o)
      else $error("column write longer than one clock");
   a_sig_pulse: assert property (
      mem_sig_wr_o |=> !mem_sig_wr_o)
      else $error("signature write longer than one clock");
   a_mem_needs_prog: assert property (
      (mem_col_wr_o || mem_erase_o || mem_sig_wr_o) |-> prog_mode_o)
      else $error("memory strobe outside programming mode");
   a_erase_clears_fuse: assert property (
      mem_erase_o |-> ##[0:3] !lock_fuse_o)
      else $error("lock fuse survived bulk erase");
   a_fuse_needs_prog: assert property (
      $rose(lock_fuse_o) |-> $past(prog_mode_o))
      else $error("lock fuse set outside programming mode");
   a_done_needs_prog: assert property (
      $changed(config_done_o) |-> $past(prog_mode_o))
      else $error("done bit changed outside programming mode");
   a_highz_alone: assert property (
      outputs_highz_o |-> !pins_from_bsr_o && !intest_o)
      else $error("high impedance mixed with another test mode");
endmodule
bind jct_tap jct_tap_properties u_jct_tap_properties (
   .clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
   .pins_from_bsr_o(pins_from_bsr_o), .outputs_highz_o(outputs_highz_o), .intest_o(intest_o),
   .prog_mode_o(prog_mode_o), .config_done_o(config_done_o), .lock_fuse_o(lock_fuse_o),
   .mem_col_wr_o(mem_col_wr_o), .mem_erase_o(mem_erase_o), .mem_sig_wr_o(mem_sig_wr_o));

// file: verification/jct_tap_host.sv
// serial test host: drives tck, tms and tdi, samples tdo
// assumes clk_i at 20 MHz; one tck period is 8 clocks, tck stands between frames
`timescale 1ns/1ps
module jct_tap_host (
   input  wire logic clk_i,
   output reg        tck_o,
   output reg        tms_o,
   output reg        tdi_o,
   input  wire logic tdo_i
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   task step(input logic m, input logic d, output logic q);
      begin
         @(negedge clk_i);
         tck_o = 1'b0;
         tms_o = m;
         tdi_o = d;
         repeat (4) @(negedge clk_i);
         tck_o = 1'b1;
         repeat (3) @(negedge clk_i);
         q = tdo_i;
      end
   endtask
   task to_reset;
      logic q;
      begin
         repeat (5) step(1'b1, 1'b0, q);
         step(1'b0, 1'b0, q);
      end
   endtask
   task scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
      logic q;
      int   i;
      begin
         dout = '0;
         step(1'b1, 1'b0, q);
         if (ir) step(1'b1, 1'b0, q);
         step(1'b0, 1'b0, q);
         step(1'b0, 1'b0, q);
         for (i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
         end
         step(1'b1, ~q, q);
         step(1'b0, ~q, q);
      end
   endtask
endmodule

// file: verification/test_jct_tap.sv
// self-checking bench for the configuration test access port
// assumes the host model drives the link; memory read data comes from here
`timescale 1ns/1ps
module test_jct_tap;
   localparam logic [31:0] TB_ID = 32'h1357_2468; // arbitrary value
   localparam logic [63:0] COLA = 64'h2AB_CDEF_0123;
   localparam logic [63:0] COLB = 64'h154_3210_FEDC;
   logic        clk_i;
   logic        rstn_i;
   logic [7:0]  pins_i;
   logic [41:0] col_rd;
   logic [31:0] sig_rd;
   wire         tck, tms, tdi, tdo_o, tdo_oe_o, pins_from_bsr_o, outputs_highz_o, intest_o;
   wire         prog_mode_o, config_done_o, lock_fuse_o, mem_col_wr_o, mem_erase_o, mem_sig_wr_o;
   wire [7:0]   bsr_drive_o;
   wire [9:0]   mem_addr_o;
   wire [41:0]  mem_col_wdata_o;
   wire [31:0]  mem_sig_wdata_o;
   wire         tdo_line;
   int          err_count, n_compared, n_wr, n_er, n_sig;
   jct_tap #(.ID(TB_ID)) u_jct_tap (.clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pins_i(pins_i), .bsr_drive_o(bsr_drive_o),
      .pins_from_bsr_o(pins_from_bsr_o), .outputs_highz_o(outputs_highz_o), .intest_o(intest_o),
      .prog_mode_o(prog_mode_o), .config_done_o(config_done_o), .lock_fuse_o(lock_fuse_o),
      .mem_addr_o(mem_addr_o), .mem_col_wr_o(mem_col_wr_o), .mem_col_wdata_o(mem_col_wdata_o),
      .mem_col_rdata_i(col_rd), .mem_erase_o(mem_erase_o), .mem_sig_wr_o(mem_sig_wr_o),
      .mem_sig_wdata_o(mem_sig_wdata_o), .mem_sig_rdata_i(sig_rd));
   // released tdo shows the inverse, so a sample outside a shift state is caught
   assign tdo_line = tdo_oe_o ? tdo_o : ~tdo_o;
   jct_tap_host u_jct_tap_host (.clk_i(clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_line));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (mem_col_wr_o === 1'b1) n_wr++;
      if (mem_erase_o === 1'b1) n_er++;
      if (mem_sig_wr_o === 1'b1) n_sig++;
   end
   task chk(input logic [63:0] got, input logic [63:0] exp);
      begin
         n_compared++;
         if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // strobes land a clock after idle entry; six clocks is ample
   task ir(input logic [7:0] op);
      logic [63:0] d;
      begin
         u_jct_tap_host.scan(1'b1, 8, {56'h0, op}, d);
         repeat (6) @(negedge clk_i);
      end
   endtask
   task dr(input int n, input logic [63:0] din, output logic [63:0] dout);
      begin
         u_jct_tap_host.scan(1'b0, n, din, dout);
         repeat (6) @(negedge clk_i);
      end
   endtask
   task t_id;
      logic [63:0] d;
      logic        q;
      begin
         u_jct_tap_host.step(1'b0, 1'b0, q);
         repeat (6) @(negedge clk_i);
         chk(tdo_oe_o, 64'h0);
         dr(32, 64'h0, d);
         chk(d, TB_ID);
      end
   endtask
   task t_bypass;
      logic [63:0] d;
      logic        q;
      begin
         u_jct_tap_host.scan(1'b1, 8, 64'h81, d);
         chk(d, 64'h16);
         dr(8, 64'hB4, d);
         chk(d, 64'h68);
         u_jct_tap_host.step(1'b1, 1'b0, q);
         u_jct_tap_host.step(1'b0, 1'b0, q);
         u_jct_tap_host.step(1'b0, 1'b0, q);
         u_jct_tap_host.to_reset;
         dr(32, 64'h0, d);
         chk(d, TB_ID);
      end
   endtask
   task t_modes;
      logic [63:0] d;
      logic [7:0]  ops [5];
      logic [2:0]  ex  [5];
      int          i;
      begin
         ops = '{8'h00, 8'h20, 8'h30, 8'h18, 8'h2C};
         ex  = '{3'b100, 3'b100, 3'b100, 3'b010, 3'b001};
         pins_i = 8'hA5;
         ir(8'h1C);
         dr(8, 64'h3C, d);
         chk(d, 64'hA5);
         for (i = 0; i < 5; i++) begin
            ir(ops[i]);
            chk({pins_from_bsr_o, outputs_highz_o, intest_o}, ex[i]);
            chk(bsr_drive_o, 64'h3C);
         end
      end
   endtask
   task t_prog;
      logic [63:0] d;
      begin
         ir(8'h15);
         chk(prog_mode_o, 64'h1);
         ir(8'h01);
         dr(10, 64'h155, d);
         chk(mem_addr_o, 64'h155);
         ir(8'h02);
         dr(42, COLA, d);
         chk(mem_col_wdata_o, COLA);
         n_wr = 0;
         ir(8'h27);
         chk(n_wr, 64'h1);
         chk(mem_addr_o, 64'h156);
         col_rd = COLB[41:0];
         ir(8'h2A);
         dr(42, COLA, d);
         chk(d, COLB);
         chk(mem_addr_o, 64'h157);
         sig_rd = 32'hC3C3_5A5A;
         ir(8'h17);
         dr(32, 64'h0F0F_1234, d);
         chk(d, 64'hC3C3_5A5A);
         n_sig = 0;
         ir(8'h1A);
         chk(n_sig, 64'h1);
         chk(mem_sig_wdata_o, 64'h0F0F_1234);
         ir(8'h09);
         chk(lock_fuse_o, 64'h1);
         ir(8'h0A);
         dr(42, 64'h0, d);
         chk(d, 64'h0);
         ir(8'h2F);
         chk(config_done_o, 64'h1);
         ir(8'h24);
         chk(config_done_o, 64'h0);
         n_er = 0;
         ir(8'h03);
         chk(n_er, 64'h1);
         chk(lock_fuse_o, 64'h0);
         ir(8'h1E);
         n_wr = 0;
         ir(8'h07);
         chk(n_wr, 64'h0);
      end
   endtask
   task complete_run;
      begin
         $display("compared %0d mismatches %0d", n_compared, err_count);
         if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      // 40k clocks, several times what the scenarios take
      #2000000;
      err_count++;
      complete_run;
   end
   initial begin
      rstn_i = 1'b0;
      pins_i = 8'h00;
      col_rd = 42'h0;
      sig_rd = 32'h0;
      err_count = 0;
      n_compared = 0;
      repeat (3) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      t_id;
      t_bypass;
      t_modes;
      t_prog;
      complete_run;
   end
endmodule
